// file: dec_map.vh
`ifndef DEC_MAP_VH
`define DEC_MAP_VH
// --------------------------------------------------------------------------
// register indices (one 32-bit word each, byte address = 4 * index)
// --------------------------------------------------------------------------
`define DEC_ADDR_W        8
`define DEC_IDX_CTRL      8'h00
`define DEC_IDX_STATUS    8'h01
`define DEC_IDX_C0_ADDR   8'h04
`define DEC_IDX_C0_AMASK  8'h05
`define DEC_IDX_C0_DATA   8'h06
`define DEC_IDX_C0_DMASK  8'h07
`define DEC_IDX_C0_CFG    8'h08
`define DEC_IDX_STRIDE    8'h08
// --------------------------------------------------------------------------
// fields
// --------------------------------------------------------------------------
`define DEC_CTRL_HALT_BIT    0
`define DEC_CTRL_RESTART_BIT 1
`define DEC_CTRL_MON_BIT     4
`define DEC_ST_HALTED_BIT    0
`define DEC_ST_CAUSE_LSB     1
`define DEC_ST_COMPR_BIT     4
`define DEC_CFG_EN_BIT       0
`define DEC_CFG_WPT_BIT      1
`define DEC_CFG_DDEP_BIT     2
`define DEC_CFG_WR_BIT       3
`define DEC_CFG_WRMASK_BIT   4
`define DEC_PC_REWIND        32'h0000_0014
// --------------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------------
`define DEC_RST_32           32'h0000_0000
`define DEC_RST_CFG          5'h00
`endif

// file: dec_debug_entry.v
// Operation
// [R1] outside logic asserts breakpoint by fetch cycle
// [R2] external breakpoint ORed with internal breakpoint
// [R3] breakpointed instruction enters execute, no writes
// [R4] latched breakpoint starts entry at execute
// [R5] prefetch abort beats breakpoint
// [R6] breakpoint beats software interrupt, undefined
// [R7] pending interrupt beats breakpoint, instruction discarded
// [R8] interrupts blocked in halt, mask bits kept
// [R9] external watchpoint ORed with internal watchpoint
// [R10] next instruction completes; single-cycle delays entry
// [R11] watchpoint entry pc is five instructions ahead
// [R12] watchpoint with abort/irq: exception then halt
// [R13] halt request synchronised, beats irq, drains
// [R14] outside must not request halt in monitor
// [R15] halted: memory idle, aborts and irqs ignored
// [R16] outside holds core reset stable while halted
// [R17] core clock gate: system normally, debug halted
// [R18] status bit 4 shows compressed-state entry
// [R19] two maskable comparators on address, data, control
// [R20] comparator is watchpoint or breakpoint, data optional
// [R21] permit low blocks requests, ack low
// [R22] halted ack high while halted
// [R23] halt request through two-flop synchroniser
`include "dec_map.vh"
module dec_debug_entry (
  input  wire        i_ref_clk,
  input  wire        i_rst,
  input  wire [7:0]  i_reg_addr,
  input  wire [31:0] i_reg_wdata,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  output reg  [31:0] o_reg_rdata,
  input  wire        i_debug_permit,
  input  wire        i_ext_instr_breakpoint_in,
  input  wire        i_ext_data_watchpoint_in,
  input  wire        i_ext_halt_request,
  input  wire        i_system_clock_gate,
  input  wire        i_debug_clock_gate,
  input  wire        i_fetch_valid,
  input  wire [31:0] i_fetch_addr,
  input  wire [31:0] i_fetch_data,
  input  wire        i_prefetch_abort,
  input  wire        i_exec_is_swi_or_undef,
  input  wire        i_exec_single_cycle,
  input  wire        i_exec_done,
  input  wire        i_data_valid,
  input  wire        i_data_write,
  input  wire [31:0] i_data_addr,
  input  wire [31:0] i_data_data,
  input  wire        i_data_abort,
  input  wire        i_exc_entry_done,
  input  wire        i_compressed_state,
  input  wire [31:0] i_core_pc,
  input  wire        i_normal_irq_low,
  input  wire        i_fast_irq_low,
  output reg         o_halted_ack,
  output reg         o_core_clock_en,
  output reg         o_issue_hold,
  output reg         o_exec_suppress,
  output reg         o_mem_idle,
  output reg         o_irq_block,
  output reg         o_abort_block,
  output reg         o_take_irq,
  output reg  [31:0] o_entry_pc
);
// --------------------------------------------------------------------------
// states
// --------------------------------------------------------------------------
localparam [2:0] ST_RUN  = 3'h0;
localparam [2:0] ST_BKPT = 3'h1;
localparam [2:0] ST_WNXT = 3'h2;
localparam [2:0] ST_WDLY = 3'h3;
localparam [2:0] ST_EXC  = 3'h4;
localparam [2:0] ST_DRN  = 3'h5;
localparam [2:0] ST_HALT = 3'h6;
localparam [1:0] CS_BKPT = 2'h1;
localparam [1:0] CS_WPT  = 2'h2;
localparam [1:0] CS_REQ  = 2'h3;

reg  [2:0]  state_reg;
reg  [2:0]  state_next;
reg  [31:0] ctrl_reg;
reg  [1:0]  cause_reg;
reg  [1:0]  cause_next;
reg         compr_reg;
reg         req_s1_reg;
reg         req_s2_reg;
reg         sw_halt_reg;
reg  [31:0] c_addr_reg  [0:1];
reg  [31:0] c_amask_reg [0:1];
reg  [31:0] c_data_reg  [0:1];
reg  [31:0] c_dmask_reg [0:1];
reg  [4:0]  c_cfg_reg   [0:1];
wire [1:0]  hit_bk;
wire [1:0]  hit_wp;
wire        irq_pend;
wire        halted;
wire        bkpt;
wire        wpt;
wire        hreq;

// --------------------------------------------------------------------------
// comparators
// --------------------------------------------------------------------------
genvar gi;
generate
  for (gi = 0; gi < 2; gi = gi + 1)
  begin : g_cmp
    wire [4:0] cfg = c_cfg_reg[gi];
    wire       is_wp = cfg[`DEC_CFG_WPT_BIT];
    wire [31:0] ad = is_wp ? i_data_addr : i_fetch_addr;
    wire [31:0] dt = is_wp ? i_data_data : i_fetch_data;
    // [R19] unmasked bits match
    wire a_ok = ((ad ^ c_addr_reg[gi]) & ~c_amask_reg[gi]) == 32'h0;
    wire d_ok = !cfg[`DEC_CFG_DDEP_BIT] |
                (((dt ^ c_data_reg[gi]) & ~c_dmask_reg[gi]) == 32'h0);
    wire w_ok = cfg[`DEC_CFG_WRMASK_BIT] |
                (i_data_write == cfg[`DEC_CFG_WR_BIT]);
    // [R20] fetch or data mode
    assign hit_bk[gi] = cfg[`DEC_CFG_EN_BIT] & !is_wp & i_fetch_valid &
                        a_ok & d_ok;
    assign hit_wp[gi] = cfg[`DEC_CFG_EN_BIT] & is_wp & i_data_valid &
                        a_ok & d_ok & w_ok;
  end
endgenerate

// --------------------------------------------------------------------------
// request qualification
// --------------------------------------------------------------------------
// [R23] two-flop synchroniser, stage one read only by stage two
always @(posedge i_ref_clk or posedge i_rst)
begin
  if (i_rst)
  begin
    req_s1_reg <= 1'b0;
    req_s2_reg <= 1'b0;
  end
  else
  begin
    req_s1_reg <= i_ext_halt_request;
    req_s2_reg <= req_s1_reg;
  end
end

// [R2] or with internal breakpoint; [R21] permit gates external
assign bkpt = (i_ext_instr_breakpoint_in & i_debug_permit & i_fetch_valid)
              | (|hit_bk);
// [R9] or with internal watchpoint
assign wpt  = (i_ext_data_watchpoint_in & i_debug_permit & i_data_valid)
              | (|hit_wp);
// [R13] external request synchronised; permit low blocks it
assign hreq = (req_s2_reg & i_debug_permit) | sw_halt_reg;
assign irq_pend = !i_normal_irq_low | !i_fast_irq_low;
assign halted   = (state_reg == ST_HALT);

// --------------------------------------------------------------------------
// entry sequencer
// --------------------------------------------------------------------------
// monitor mode turns comparator hits into aborts elsewhere, so halt
// entry here only acts with the monitor bit clear
always @*
begin
  state_next = state_reg;
  cause_next = cause_reg;
  case (state_reg)
    ST_RUN:
    begin
      if (!ctrl_reg[`DEC_CTRL_MON_BIT])
      begin
        // [R13] request outranks interrupts
        if (hreq)
        begin
          state_next = ST_DRN;
          cause_next = CS_REQ;
        end
        // [R12] watchpoint with abort or irq: exception first
        else if (wpt && (i_data_abort || irq_pend))
        begin
          state_next = ST_EXC;
          cause_next = CS_WPT;
        end
        else if (wpt)
        begin
          state_next = ST_WNXT;
          cause_next = CS_WPT;
        end
        // [R5] prefetch abort wins; [R7] irq wins, refetch later
        else if (bkpt && !i_prefetch_abort && !irq_pend)
        begin
          state_next = ST_BKPT;
          cause_next = CS_BKPT;
        end
      end
    end
    // [R4] entry decode during breakpointed execute
    ST_BKPT:
      state_next = ST_HALT;
    // [R10] following instruction completes first
    ST_WNXT:
      if (i_exec_done)
        state_next = i_exec_single_cycle ? ST_WDLY : ST_HALT;
    ST_WDLY:
      state_next = ST_HALT;
    ST_EXC:
      if (i_exc_entry_done)
        state_next = ST_HALT;
    // [R13] wait for memory and write stages
    ST_DRN:
      if (i_exec_done)
        state_next = ST_HALT;
    ST_HALT:
      if (ctrl_reg[`DEC_CTRL_RESTART_BIT])
        state_next = ST_RUN;
    default:
      state_next = ST_RUN;
  endcase
end

always @(posedge i_ref_clk or posedge i_rst)
begin
  if (i_rst)
  begin
    state_reg       <= ST_RUN;
    cause_reg       <= 2'h0;
    compr_reg       <= 1'b0;
    o_halted_ack    <= 1'b0;
    o_core_clock_en <= 1'b0;
    o_issue_hold    <= 1'b0;
    o_exec_suppress <= 1'b0;
    o_mem_idle      <= 1'b0;
    o_irq_block     <= 1'b0;
    o_abort_block   <= 1'b0;
    o_take_irq      <= 1'b0;
    o_entry_pc      <= `DEC_RST_32;
  end
  else
  begin
    state_reg <= state_next;
    cause_reg <= cause_next;
    // [R18] state captured at entry
    if (state_next == ST_HALT && !halted)
      compr_reg <= i_compressed_state;
    // [R11] pc five instructions ahead; rewind constant for restart
    if (state_next == ST_HALT && !halted)
      o_entry_pc <= i_core_pc;
    // [R22] ack while halted; [R21] forced low without permit
    o_halted_ack <= (state_next == ST_HALT) & i_debug_permit;
    // [R17] clock gate select
    o_core_clock_en <= (state_next == ST_HALT) ? i_debug_clock_gate
                                               : i_system_clock_gate;
    // [R13] no new issue while draining
    o_issue_hold <= (state_next == ST_DRN) || (state_next == ST_HALT);
    // [R3] [R6] breakpointed instruction suppressed, even swi/undef
    o_exec_suppress <= (state_next == ST_BKPT) ||
                       (state_reg == ST_WDLY) ||
                       (state_next == ST_HALT);
    // [R15] both memory ports idle, aborts ignored
    o_mem_idle    <= (state_next == ST_HALT);
    o_abort_block <= (state_next == ST_HALT);
    // [R8] interrupts blocked, psr mask bits untouched
    o_irq_block <= (state_next == ST_HALT) || (state_next == ST_DRN);
    // [R7] irq taken over breakpointed instruction
    o_take_irq <= (state_reg == ST_RUN) && bkpt && irq_pend &&
                  !hreq && !i_prefetch_abort;
  end
end

// --------------------------------------------------------------------------
// register file
// --------------------------------------------------------------------------
integer k;
always @(posedge i_ref_clk or posedge i_rst)
begin
  if (i_rst)
  begin
    ctrl_reg    <= `DEC_RST_32;
    sw_halt_reg <= 1'b0;
    for (k = 0; k < 2; k = k + 1)
    begin
      c_addr_reg[k]  <= `DEC_RST_32;
      c_amask_reg[k] <= `DEC_RST_32;
      c_data_reg[k]  <= `DEC_RST_32;
      c_dmask_reg[k] <= `DEC_RST_32;
      c_cfg_reg[k]   <= `DEC_RST_CFG;
    end
  end
  else
  begin
    // restart is a self-clearing pulse
    ctrl_reg[`DEC_CTRL_RESTART_BIT] <= 1'b0;
    // software halt request stays until taken
    if (state_reg == ST_RUN && state_next == ST_DRN)
      sw_halt_reg <= 1'b0;
    if (i_reg_wr)
    begin
      if (i_reg_addr == `DEC_IDX_CTRL)
      begin
        ctrl_reg <= i_reg_wdata;
        // set wins over the take in the same cycle
        if (i_reg_wdata[`DEC_CTRL_HALT_BIT])
          sw_halt_reg <= 1'b1;
      end
      for (k = 0; k < 2; k = k + 1)
      begin
        if (i_reg_addr == `DEC_IDX_C0_ADDR + k[7:0] * `DEC_IDX_STRIDE)
          c_addr_reg[k] <= i_reg_wdata;
        if (i_reg_addr == `DEC_IDX_C0_AMASK + k[7:0] * `DEC_IDX_STRIDE)
          c_amask_reg[k] <= i_reg_wdata;
        if (i_reg_addr == `DEC_IDX_C0_DATA + k[7:0] * `DEC_IDX_STRIDE)
          c_data_reg[k] <= i_reg_wdata;
        if (i_reg_addr == `DEC_IDX_C0_DMASK + k[7:0] * `DEC_IDX_STRIDE)
          c_dmask_reg[k] <= i_reg_wdata;
        if (i_reg_addr == `DEC_IDX_C0_CFG + k[7:0] * `DEC_IDX_STRIDE)
          c_cfg_reg[k] <= i_reg_wdata[4:0];
      end
    end
  end
end

// unmapped addresses read zero
reg [31:0] rd_mux;
always @*
begin
  rd_mux = 32'h0;
  case (i_reg_addr)
    `DEC_IDX_CTRL:
      rd_mux = ctrl_reg;
    `DEC_IDX_STATUS:
    begin
      rd_mux[`DEC_ST_HALTED_BIT] = halted;
      rd_mux[`DEC_ST_CAUSE_LSB +: 2] = cause_reg;
      // [R18] compressed-state flag in bit 4
      rd_mux[`DEC_ST_COMPR_BIT] = compr_reg;
    end
    `DEC_IDX_C0_ADDR: rd_mux = c_addr_reg[0];
    `DEC_IDX_C0_AMASK: rd_mux = c_amask_reg[0];
    `DEC_IDX_C0_DATA: rd_mux = c_data_reg[0];
    `DEC_IDX_C0_DMASK: rd_mux = c_dmask_reg[0];
    `DEC_IDX_C0_CFG: rd_mux = {27'h0, c_cfg_reg[0]};
    `DEC_IDX_C0_ADDR + `DEC_IDX_STRIDE: rd_mux = c_addr_reg[1];
    `DEC_IDX_C0_AMASK + `DEC_IDX_STRIDE: rd_mux = c_amask_reg[1];
    `DEC_IDX_C0_DATA + `DEC_IDX_STRIDE: rd_mux = c_data_reg[1];
    `DEC_IDX_C0_DMASK + `DEC_IDX_STRIDE: rd_mux = c_dmask_reg[1];
    `DEC_IDX_C0_CFG + `DEC_IDX_STRIDE: rd_mux = {27'h0, c_cfg_reg[1]};
    default:
      rd_mux = 32'h0;
  endcase
end

always @(posedge i_ref_clk or posedge i_rst)
begin
  if (i_rst)
    o_reg_rdata <= `DEC_RST_32;
  else if (i_reg_rd)
    o_reg_rdata <= rd_mux;
  else
    o_reg_rdata <= 32'h0;
end

endmodule // dec_debug_entry

// file: dec_debug_entry_props.sv
module dec_debug_entry_props (
  input logic        i_ref_clk,
  input logic        i_rst,
  input logic [7:0]  i_reg_addr,
  input logic [31:0] i_reg_wdata,
  input logic        i_reg_wr,
  input logic        i_reg_rd,
  input logic [31:0] o_reg_rdata,
  input logic        i_debug_permit,
  input logic        i_ext_instr_breakpoint_in,
  input logic        i_ext_halt_request,
  input logic        i_system_clock_gate,
  input logic        i_debug_clock_gate,
  input logic        i_fetch_valid,
  input logic        i_prefetch_abort,
  input logic        i_data_valid,
  input logic        i_normal_irq_low,
  input logic        i_fast_irq_low,
  input logic        o_halted_ack,
  input logic        o_core_clock_en,
  input logic        o_issue_hold,
  input logic        o_exec_suppress,
  input logic        o_mem_idle,
  input logic        o_irq_block,
  input logic        o_abort_block,
  input logic        o_take_irq
);
  logic       mon_q;
  logic [1:0] warm;
  logic       run_ok;
  logic       bk_hit;
  logic       irq_pend;
  // monitor bit tracked here since the checker cannot see it otherwise
  always @(posedge i_ref_clk or posedge i_rst)
    if (i_rst)
    begin
      mon_q <= 1'b0;
      warm  <= 2'h0;
    end
    else
    begin
      if (i_reg_wr && i_reg_addr == 8'h00)
        mon_q <= i_reg_wdata[4];
      if (warm != 2'h3)
        warm <= warm + 2'h1;
    end
  assign run_ok = i_debug_permit && !mon_q && !o_issue_hold && !o_halted_ack
                  && !o_exec_suppress && warm == 2'h3;
  assign bk_hit = run_ok && i_fetch_valid && i_ext_instr_breakpoint_in
                  && !i_data_valid;
  assign irq_pend = !i_normal_irq_low || !i_fast_irq_low;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_bkpt_entry: assert property (
    bk_hit && !i_prefetch_abort && !irq_pend
    |=> o_exec_suppress ##1 o_halted_ack)
    else $error("breakpoint entry late");
  a_pabt_wins: assert property (
    bk_hit && i_prefetch_abort |=> !o_exec_suppress ##1 !o_halted_ack)
    else $error("breakpoint over abort");
  a_irq_wins: assert property (
    bk_hit && !i_prefetch_abort && irq_pend |-> ##[1:2] o_take_irq)
    else $error("interrupt not taken");
  a_halt_sync: assert property (
    run_ok && $rose(i_ext_halt_request)
    |-> ##[1:4] (o_issue_hold || o_halted_ack))
    else $error("halt request lost");
  a_ack_quiet: assert property (
    o_halted_ack |-> o_mem_idle && o_irq_block && o_abort_block)
    else $error("halt not quiet");
  a_permit_low: assert property (
    !i_debug_permit ##1 !i_debug_permit |-> !o_halted_ack)
    else $error("ack with permit low");
  a_ack_holds: assert property (
    o_halted_ack && i_debug_permit && !i_reg_wr && !$past(i_reg_wr)
    |=> o_halted_ack || !i_debug_permit)
    else $error("ack dropped early");
  a_restart_drop: assert property (
    o_halted_ack && i_reg_wr && i_reg_addr == 8'h00 && i_reg_wdata[1]
    |-> ##[1:2] !o_halted_ack)
    else $error("restart ignored");
  a_clk_debug: assert property (
    o_halted_ack && $past(o_halted_ack) && $stable(i_debug_clock_gate)
    |-> o_core_clock_en == i_debug_clock_gate)
    else $error("debug clock gate");
  a_clk_system: assert property (
    warm == 2'h3 && !o_halted_ack && !$past(o_halted_ack)
    && $stable(i_system_clock_gate)
    |-> o_core_clock_en == i_system_clock_gate)
    else $error("system clock gate");
  a_rdata_idle: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
    else $error("read data outside slot");
  c_bkpt: cover property (bk_hit);
  c_halt: cover property ($rose(o_halted_ack));
  c_irq: cover property (o_take_irq);
endmodule // dec_debug_entry_props

bind dec_debug_entry dec_debug_entry_props dec_debug_entry_props_inst (.*);

// file: dec_sys_model.sv
module dec_sys_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_halted_ack,
  input  wire logic       i_take_irq,
  input  wire logic       i_data_abort,
  input  wire logic [3:0] i_gap,
  output logic            o_exec_done,
  output logic            o_exc_entry_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cnt_reg;
  logic [1:0] exc_reg;
  // core reset never touched from here
  // retires one instruction per gap; none while halted
  always @(posedge i_ref_clk or posedge i_rst)
    if (i_rst)
    begin
      cnt_reg          <= 4'h0;
      exc_reg          <= 2'h0;
      o_exec_done      <= 1'b0;
      o_exc_entry_done <= 1'b0;
    end
    else
    begin
      o_exec_done <= !i_halted_ack && cnt_reg == 4'h0;
      cnt_reg     <= (cnt_reg == 4'h0) ? i_gap : cnt_reg - 4'h1;
      // exception entry takes a few cycles
      exc_reg <= (i_take_irq || i_data_abort) ? 2'h3
                 : (exc_reg != 2'h0 ? exc_reg - 2'h1 : 2'h0);
      o_exc_entry_done <= exc_reg == 2'h1;
    end
endmodule // dec_sys_model

// file: dec_debug_entry_tb.sv
module dec_debug_entry_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_ref_clk, i_rst, i_reg_wr, i_reg_rd, i_debug_permit, i_fetch_valid;
  logic i_ext_instr_breakpoint_in, i_ext_data_watchpoint_in, i_data_abort;
  logic i_ext_halt_request, i_system_clock_gate, i_debug_clock_gate;
  logic i_prefetch_abort, i_exec_is_swi_or_undef, i_exec_single_cycle;
  logic i_exec_done, i_data_valid, i_data_write, i_exc_entry_done;
  logic i_compressed_state, i_normal_irq_low, i_fast_irq_low, o_halted_ack;
  logic o_core_clock_en, o_issue_hold, o_exec_suppress, o_mem_idle;
  logic o_irq_block, o_abort_block, o_take_irq;
  logic [7:0]  i_reg_addr;
  logic [3:0]  gap;
  logic [31:0] i_reg_wdata, o_reg_rdata, i_fetch_addr, i_fetch_data;
  logic [31:0] i_data_addr, i_data_data, i_core_pc, o_entry_pc;
  int          failures = 0;
  int          checks = 0;
  int          cyc = 0;
  dec_debug_entry dec_debug_entry_inst (.*);
  dec_sys_model dec_sys_model_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_halted_ack(o_halted_ack), .i_take_irq(o_take_irq),
    .i_data_abort(i_data_abort), .i_gap(gap), .o_exec_done(i_exec_done),
    .o_exc_entry_done(i_exc_entry_done));
  always #5 i_ref_clk = ~i_ref_clk;
  // debug gate wanders so the clock select is seen switching
  always @(posedge i_ref_clk)
  begin
    cyc++;
    i_debug_clock_gate <= cyc[2];
    if (cyc == 3000)
    begin
      failures++;
      summarize();
    end
  end
  task automatic summarize();
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    i_reg_wr    <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_wr    <= 1'b0;
    i_reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string nm);
    @(posedge i_ref_clk);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_ref_clk);
    i_reg_rd <= 1'b0;
    #1 chk(nm, e, o_reg_rdata);
  endtask
  task automatic wait_ack(input logic lv);
    int n;
    n = 0;
    while (o_halted_ack !== lv && n < 40)
    begin
      @(posedge i_ref_clk);
      #1 n++;
    end
    chk("halted_ack", {31'h0, lv}, {31'h0, o_halted_ack});
  endtask
  task automatic enter(input logic [31:0] st);
    wait_ack(1'b1);
    chk("quiet", 32'h7, {29'h0, o_mem_idle, o_irq_block, o_abort_block});
    chk("entry_pc", i_core_pc, o_entry_pc);
    rd(8'h01, st, "status");
    wr(8'h00, 32'h2);
    wait_ack(1'b0);
  endtask
  task automatic fetch(input logic [31:0] a, input logic bk, input logic pa);
    @(posedge i_ref_clk);
    i_fetch_valid             <= 1'b1;
    i_fetch_addr              <= a;
    // breakpoint stands in the fetch cycle itself
    i_ext_instr_breakpoint_in <= bk;
    i_prefetch_abort          <= pa;
    @(posedge i_ref_clk);
    i_fetch_valid             <= 1'b0;
    i_fetch_addr              <= ~a;
    i_ext_instr_breakpoint_in <= 1'b0;
    i_prefetch_abort          <= 1'b0;
  endtask
  task automatic dacc(input logic [31:0] a, input logic wp, input logic ab);
    @(posedge i_ref_clk);
    i_data_valid             <= 1'b1;
    i_data_addr              <= a;
    i_ext_data_watchpoint_in <= wp;
    i_data_abort             <= ab;
    @(posedge i_ref_clk);
    i_data_valid             <= 1'b0;
    i_data_addr              <= ~a;
    i_ext_data_watchpoint_in <= 1'b0;
    i_data_abort             <= 1'b0;
  endtask
  task automatic idle_chk();
    repeat (10) @(posedge i_ref_clk);
    #1 chk("halted_ack", 32'h0, {31'h0, o_halted_ack});
  endtask
  initial
  begin
    {i_ref_clk, i_reg_wr, i_reg_rd, i_fetch_valid, i_data_valid} = 5'h00;
    {i_ext_instr_breakpoint_in, i_ext_data_watchpoint_in, i_data_abort} = 3'h0;
    {i_ext_halt_request, i_prefetch_abort, i_exec_is_swi_or_undef} = 3'h0;
    {i_exec_single_cycle, i_data_write, i_compressed_state} = 3'h0;
    {i_rst, i_debug_permit, i_normal_irq_low, i_fast_irq_low} = 4'hf;
    i_system_clock_gate = 1'b1;
    {i_reg_addr, gap} = 12'h000;
    {i_reg_wdata, i_fetch_addr, i_data_addr} = 96'h0;
    i_fetch_data = 32'h1234_5678;
    i_data_data = 32'h5a5a_a5a5;
    i_core_pc = 32'h0000_1000;
    repeat (20) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    rd(8'h3f, 32'h0, "unmapped");
    i_compressed_state <= 1'b1;
    wr(8'h00, 32'h1);
    enter(32'h17);
    i_compressed_state <= 1'b0;
    i_exec_is_swi_or_undef <= 1'b1;
    fetch(32'h40, 1'b1, 1'b0);
    #1 chk("suppress", 32'h1, {31'h0, o_exec_suppress});
    enter(32'h3);
    i_exec_is_swi_or_undef <= 1'b0;
    gap <= 4'h4;
    dacc(32'h80, 1'b1, 1'b0);
    enter(32'h5);
    gap <= 4'h0;
    i_exec_single_cycle <= 1'b1;
    // let the retire counter settle so completion is immediate
    repeat (5) @(posedge i_ref_clk);
    dacc(32'h80, 1'b1, 1'b0);
    @(posedge i_ref_clk);
    #1 chk("wpt_delay", 32'h0, {31'h0, o_halted_ack});
    enter(32'h5);
    i_exec_single_cycle <= 1'b0;
    dacc(32'h84, 1'b1, 1'b1);
    enter(32'h5);
    fetch(32'h40, 1'b1, 1'b1);
    idle_chk();
    i_normal_irq_low <= 1'b0;
    fetch(32'h40, 1'b1, 1'b0);
    #1 chk("take_irq", 32'h1, {31'h0, o_take_irq});
    idle_chk();
    i_ext_halt_request <= 1'b1;
    wait_ack(1'b1);
    i_ext_halt_request <= 1'b0;
    enter(32'h7);
    i_normal_irq_low <= 1'b1;
    i_debug_permit <= 1'b0;
    i_ext_halt_request <= 1'b1;
    fetch(32'h40, 1'b1, 1'b0);
    dacc(32'h80, 1'b1, 1'b0);
    idle_chk();
    i_ext_halt_request <= 1'b0;
    repeat (5) @(posedge i_ref_clk);
    i_debug_permit <= 1'b1;
    // halt request stays low while the monitor bit is set
    wr(8'h00, 32'h10);
    fetch(32'h40, 1'b1, 1'b0);
    idle_chk();
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h100);
    wr(8'h05, 32'h0);
    wr(8'h08, 32'h1);
    fetch(32'h104, 1'b0, 1'b0);
    idle_chk();
    fetch(32'h100, 1'b0, 1'b0);
    enter(32'h3);
    wr(8'h08, 32'h0);
    wr(8'h0c, 32'h200);
    wr(8'h0d, 32'hf);
    wr(8'h0e, 32'h5a5a_a5a4);
    wr(8'h0f, 32'h0);
    wr(8'h10, 32'h17);
    rd(8'h0e, 32'h5a5a_a5a4, "c1_data");
    dacc(32'h20c, 1'b0, 1'b0);
    idle_chk();
    wr(8'h0f, 32'h1);
    dacc(32'h20c, 1'b0, 1'b0);
    enter(32'h5);
    wr(8'h10, 32'h0);
    summarize();
  end
endmodule // dec_debug_entry_tb
